// >>> src/counter_err_pkg.sv
// Constants for configuration checking and error reporting of the counter unit
package counter_err_pkg;

  // ===========================================================================
  // Settings memory area placement
  localparam int unsigned AREA_BASE_WORD = 20000;
  localparam int unsigned AREA_UNIT_STRIDE = 100;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned UNIT_W = 7;

  // ===========================================================================
  // Word offsets inside one counter's block
  localparam int unsigned COUNTERS = 2;
  localparam int unsigned WORDS_PER_COUNTER = 14;
  localparam int unsigned AREA_WORDS = COUNTERS * WORDS_PER_COUNTER;
  localparam int unsigned OFF_TYPE = 0;
  localparam int unsigned OFF_MODE = 1;
  localparam int unsigned OFF_ERR_EN = 2;
  localparam int unsigned OFF_MIN = 3;
  localparam int unsigned OFF_MAX = 4;
  localparam int unsigned OFF_INIT = 5;
  localparam int unsigned OFF_DATA = 6;
  localparam int unsigned DATA_ENTRIES = 4;

  // ===========================================================================
  // Setting word encodings
  localparam logic [15:0] TYPE_CIRCULAR = 16'h0000;
  localparam logic [15:0] TYPE_LINEAR = 16'h0001;
  localparam logic [15:0] MODE_RANGE = 16'h0000;
  localparam logic [15:0] MODE_COMPARE = 16'h0001;
  localparam logic [15:0] SELECT_WORD_MAX = 16'h0001;

  // ===========================================================================
  // Check sequence
  localparam logic [3:0] CHECK_STEPS = 4'h9;
  localparam logic [3:0] STEP_BOUNDS = 4'h3;
  localparam logic [3:0] STEP_INIT = 4'h4;
  localparam logic [3:0] STEP_DATA = 4'h5;

  // ===========================================================================
  // Primary error codes
  localparam logic [15:0] CODE_OUT_OF_RANGE = 16'h0300;
  localparam logic [15:0] CODE_BAD_DIGIT = 16'h0310;
  localparam logic [15:0] CODE_BAD_INITIAL = 16'h0311;
  localparam logic [15:0] CODE_LIMITS_SWAPPED = 16'h0320;
  localparam logic [15:0] CODE_LIMIT_OUTSIDE = 16'h0330;
  localparam logic [15:0] CODE_DUPLICATE_CV = 16'h0331;
  localparam logic [15:0] CODE_OVERFLOW = 16'h0450;
  localparam logic [15:0] CODE_UNDERFLOW = 16'h0460;

  // ===========================================================================
  // Error list
  localparam int unsigned LIST_DEPTH = 30;
  localparam int unsigned LIST_PTR_W = 5;

  typedef enum logic [1:0] {
    ST_LOAD  = 2'b00,
    ST_CHECK = 2'b01,
    ST_RUN   = 2'b11,
    ST_HALT  = 2'b10
  } unit_state_type;

endpackage

// >>> src/error_list.sv
// Ordered error list with next-entry readout
`timescale 1ns/1ps
`default_nettype none
module error_list (
  // Clock and reset
  input  wire logic                                   core_clk,
  input  wire logic                                   sys_rst,
  // Control
  input  wire logic                                   clear,
  input  wire logic                                   push,
  input  wire logic [15:0]                            push_primary,
  input  wire logic [15:0]                            push_secondary,
  input  wire logic                                   advance_error_list,
  // Outputs
  output logic      [15:0]                            primary_error_word,
  output logic      [15:0]                            secondary_error_word,
  output logic                                        any_error_flag,
  output logic      [counter_err_pkg::LIST_PTR_W-1:0] entry_count
);
  import counter_err_pkg::*;

  logic [31:0]           entry_mem [0:LIST_DEPTH-1];
  logic [LIST_PTR_W-1:0] count_reg;
  logic [LIST_PTR_W-1:0] read_ptr_reg;
  logic                  advance_prev_reg;
  logic                  advance_pend_reg;
  logic                  advance_rise;

  assign advance_rise = advance_error_list & ~advance_prev_reg;
  assign entry_count  = count_reg;

  // ===========================================================================
  // Entry storage in order of arrival
  always_ff @(posedge core_clk) begin
    if (push && count_reg < LIST_PTR_W'(LIST_DEPTH)) begin
      entry_mem[count_reg] <= {push_primary, push_secondary};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || clear) begin
      count_reg <= '0;
    end else if (push && count_reg < LIST_PTR_W'(LIST_DEPTH)) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // ===========================================================================
  // Rising edge of the advance control, held while a push owns the words
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      advance_prev_reg <= 1'b0;
      advance_pend_reg <= 1'b0;
    end else begin
      advance_prev_reg <= advance_error_list;
      if (clear) begin
        advance_pend_reg <= 1'b0;
      end else if (push) begin
        advance_pend_reg <= advance_pend_reg | advance_rise;
      end else begin
        advance_pend_reg <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // Error code words and readout pointer
  always_ff @(posedge core_clk) begin
    if (sys_rst || clear) begin
      primary_error_word   <= 16'h0000;
      secondary_error_word <= 16'h0000;
      read_ptr_reg         <= '0;
    end else if (push) begin
      primary_error_word   <= push_primary;
      secondary_error_word <= push_secondary;
    end else if (advance_rise || advance_pend_reg) begin
      if (read_ptr_reg >= count_reg) begin
        primary_error_word   <= 16'h0000;
        secondary_error_word <= 16'h0000;
        read_ptr_reg         <= '0;
      end else begin
        primary_error_word   <= entry_mem[read_ptr_reg][31:16];
        secondary_error_word <= entry_mem[read_ptr_reg][15:0];
        read_ptr_reg         <= read_ptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || clear) begin
      any_error_flag <= 1'b0;
    end else if (push) begin
      any_error_flag <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> src/config_check_error_reporter.sv
// Configuration checker and error reporter for the two-channel counter unit
//
// Contract
// - Settings are checked only in initialization after reset or unit restart.
// - A failed check records the error and stops all counting.
// - First setting word is 20000 plus 100 times unit number; offsets from it.
// - Out of range setting word gives 0300 with its BCD offset.
// - BCD word with a digit above 9 gives 0310 with its BCD offset.
// - Initial value outside counting range gives 0311 with its BCD offset.
// - Upper limit below lower limit gives 0320 naming counter and range.
// - Counter errors carry data number in bits 11:0, counter number in 15:12.
// - Range mode limit outside counting range gives 0330 with counter and range.
// - Comparison value outside counting range gives 0330 with counter and value.
// - Equal comparison values of one counter give 0331 with counter and value.
// - Overflow and underflow are reported only for enabled linear counters.
// - Enabled linear counter overflow gives 0450 with counter number.
// - Enabled linear counter underflow gives 0460 with counter number.
// - Host reads stored errors via the advance control through both code words.
// - Any error copies codes to the words, logs it, sets the error flag.
// - Up to thirty errors are kept in order of occurrence.
// - Each advance edge loads next entry; past the last gives zero, then wraps.
`timescale 1ns/1ps
`default_nettype none
module config_check_error_reporter (
  // Clock and reset
  input  wire logic                                   core_clk,
  input  wire logic                                   sys_rst,
  // Unit control
  input  wire logic [counter_err_pkg::UNIT_W-1:0]     unit_number,
  input  wire logic                                   unit_restart,
  output logic                                        count_enable,
  output logic                                        init_busy,
  // Settings memory area read port
  output logic      [counter_err_pkg::ADDR_W-1:0]     settings_addr,
  output logic                                        settings_rd,
  input  wire logic [15:0]                            settings_data,
  // Counter events
  input  wire logic [1:0]                             overflow_event,
  input  wire logic [1:0]                             underflow_event,
  // Error reporting
  input  wire logic                                   advance_error_list,
  output logic      [15:0]                            primary_error_word,
  output logic      [15:0]                            secondary_error_word,
  output logic                                        any_error_flag,
  output logic      [counter_err_pkg::LIST_PTR_W-1:0] error_count
);
  import counter_err_pkg::*;

  unit_state_type state_reg;
  logic [15:0]           settings_reg [0:AREA_WORDS-1];
  logic [ADDR_W-1:0]     base_reg;
  logic [LIST_PTR_W-1:0] issue_idx_reg;
  logic [LIST_PTR_W-1:0] capture_idx_reg;
  logic                  capture_valid_reg;
  logic                  chk_ctr_reg;
  logic [3:0]            chk_sub_reg;
  logic                  found_reg;
  logic [3:0]            pending_reg;
  logic                  chk_hit;
  logic [15:0]           chk_primary;
  logic [15:0]           chk_secondary;
  logic                  push;
  logic [15:0]           push_primary;
  logic [15:0]           push_secondary;
  logic [1:0]            event_allowed;
  logic                  last_step;

  // ===========================================================================
  // Helpers
  function automatic logic bcd_bad(input logic [15:0] w);
    bcd_bad = (w[3:0] > 4'h9) || (w[7:4] > 4'h9) || (w[11:8] > 4'h9) || (w[15:12] > 4'h9);
  endfunction

  function automatic logic [15:0] offset_bcd(input logic [LIST_PTR_W-1:0] off);
    logic [LIST_PTR_W-1:0] tens;
    logic [LIST_PTR_W-1:0] ones;
    tens = off / LIST_PTR_W'(10);
    ones = off % LIST_PTR_W'(10);
    offset_bcd = {8'h00, tens[3:0], ones[3:0]};
  endfunction

  function automatic logic [15:0] word_at(input logic ctr, input logic [3:0] off);
    logic [LIST_PTR_W-1:0] idx;
    idx = (ctr ? LIST_PTR_W'(WORDS_PER_COUNTER) : '0) + LIST_PTR_W'(off);
    word_at = settings_reg[idx];
  endfunction

  // ===========================================================================
  // Sequence control
  assign last_step = (chk_sub_reg == CHECK_STEPS - 4'h1) && chk_ctr_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst || unit_restart) begin
      state_reg <= ST_LOAD;
    end else begin
      case (state_reg)
        ST_LOAD: begin
          if (capture_valid_reg && capture_idx_reg == LIST_PTR_W'(AREA_WORDS - 1)) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (last_step) begin
            state_reg <= (found_reg || chk_hit) ? ST_HALT : ST_RUN;
          end
        end
        ST_RUN:  state_reg <= ST_RUN;
        ST_HALT: state_reg <= ST_HALT;
        default: state_reg <= ST_LOAD;
      endcase
    end
  end

  assign count_enable = (state_reg == ST_RUN);
  assign init_busy    = (state_reg == ST_LOAD) || (state_reg == ST_CHECK);

  // ===========================================================================
  // Settings fetch, one word per cycle, data one cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst || unit_restart) begin
      base_reg <= '0;
    end else if (state_reg == ST_LOAD && issue_idx_reg == '0) begin
      base_reg <= ADDR_W'(AREA_BASE_WORD) + ADDR_W'(AREA_UNIT_STRIDE) * ADDR_W'(unit_number);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || unit_restart) begin
      issue_idx_reg     <= '0;
      settings_rd       <= 1'b0;
      settings_addr     <= '0;
      capture_valid_reg <= 1'b0;
      capture_idx_reg   <= '0;
    end else begin
      capture_valid_reg <= settings_rd;
      capture_idx_reg   <= issue_idx_reg - LIST_PTR_W'(2);
      settings_rd       <= 1'b0;
      if (state_reg == ST_LOAD && issue_idx_reg != '0
          && issue_idx_reg <= LIST_PTR_W'(AREA_WORDS)) begin
        settings_rd   <= 1'b1;
        settings_addr <= base_reg + ADDR_W'(issue_idx_reg - 1'b1);
      end
      if (state_reg == ST_LOAD && issue_idx_reg <= LIST_PTR_W'(AREA_WORDS)) begin
        issue_idx_reg <= issue_idx_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (capture_valid_reg) begin
      settings_reg[capture_idx_reg] <= settings_data;
    end
  end

  // ===========================================================================
  // Check steps: select words, bounds, initial value, four data entries
  always_ff @(posedge core_clk) begin
    if (sys_rst || unit_restart) begin
      chk_ctr_reg <= 1'b0;
      chk_sub_reg <= 4'h0;
      found_reg   <= 1'b0;
    end else if (state_reg == ST_CHECK) begin
      found_reg <= found_reg | chk_hit;
      if (chk_sub_reg == CHECK_STEPS - 4'h1) begin
        chk_sub_reg <= 4'h0;
        chk_ctr_reg <= 1'b1;
      end else begin
        chk_sub_reg <= chk_sub_reg + 4'h1;
      end
    end
  end

  always_comb begin
    logic [15:0] cmin;
    logic [15:0] cmax;
    logic [15:0] w;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [3:0]  e;
    logic [LIST_PTR_W-1:0] base_off;
    cmin          = word_at(chk_ctr_reg, 4'(OFF_MIN));
    cmax          = word_at(chk_ctr_reg, 4'(OFF_MAX));
    w             = word_at(chk_ctr_reg, chk_sub_reg);
    e             = chk_sub_reg - STEP_DATA;
    lo            = word_at(chk_ctr_reg, 4'(OFF_DATA) + {e[2:0], 1'b0});
    hi            = word_at(chk_ctr_reg, 4'(OFF_DATA) + {e[2:0], 1'b1});
    base_off      = chk_ctr_reg ? LIST_PTR_W'(WORDS_PER_COUNTER) : '0;
    chk_hit       = 1'b0;
    chk_primary   = 16'h0000;
    chk_secondary = {4'(chk_ctr_reg) + 4'h1, 8'h00, e + 4'h1};
    if (chk_sub_reg < STEP_BOUNDS) begin
      chk_secondary = offset_bcd(base_off + LIST_PTR_W'(chk_sub_reg));
      if (bcd_bad(w)) begin
        chk_hit     = 1'b1;
        chk_primary = CODE_BAD_DIGIT;
      end else if (w > SELECT_WORD_MAX) begin
        chk_hit     = 1'b1;
        chk_primary = CODE_OUT_OF_RANGE;
      end
    end else if (chk_sub_reg == STEP_BOUNDS) begin
      chk_secondary = offset_bcd(base_off + LIST_PTR_W'(OFF_MAX));
      if (cmax < cmin) begin
        chk_hit     = 1'b1;
        chk_primary = CODE_OUT_OF_RANGE;
      end
    end else if (chk_sub_reg == STEP_INIT) begin
      chk_secondary = offset_bcd(base_off + LIST_PTR_W'(OFF_INIT));
      w             = word_at(chk_ctr_reg, 4'(OFF_INIT));
      if (w < cmin || w > cmax) begin
        chk_hit     = 1'b1;
        chk_primary = CODE_BAD_INITIAL;
      end
    end else if (word_at(chk_ctr_reg, 4'(OFF_MODE)) == MODE_RANGE) begin
      if (hi < lo) begin
        chk_hit     = 1'b1;
        chk_primary = CODE_LIMITS_SWAPPED;
      end else if (lo < cmin || hi > cmax) begin
        chk_hit     = 1'b1;
        chk_primary = CODE_LIMIT_OUTSIDE;
      end
    end else begin
      lo = word_at(chk_ctr_reg, 4'(OFF_DATA) + e);
      if (lo < cmin || lo > cmax) begin
        chk_hit     = 1'b1;
        chk_primary = CODE_LIMIT_OUTSIDE;
      end else begin
        for (int i = 0; i < DATA_ENTRIES; i++) begin
          if (4'(i) < e && word_at(chk_ctr_reg, 4'(OFF_DATA + i)) == lo) begin
            chk_hit     = 1'b1;
            chk_primary = CODE_DUPLICATE_CV;
          end
        end
      end
    end
  end

  // ===========================================================================
  // Run-time overflow and underflow, held until logged
  always_comb begin
    for (int c = 0; c < COUNTERS; c++) begin
      event_allowed[c] = (word_at(1'(c), 4'(OFF_TYPE)) == TYPE_LINEAR)
                         && (word_at(1'(c), 4'(OFF_ERR_EN)) != 16'h0000);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || unit_restart) begin
      pending_reg <= 4'h0;
    end else if (state_reg == ST_RUN) begin
      pending_reg <= (pending_reg & ~(push ? (pending_reg & -pending_reg) : 4'h0))
                     | {underflow_event & event_allowed, overflow_event & event_allowed};
    end
  end

  always_comb begin
    push           = 1'b0;
    push_primary   = 16'h0000;
    push_secondary = 16'h0000;
    if (state_reg == ST_CHECK) begin
      push           = chk_hit;
      push_primary   = chk_primary;
      push_secondary = chk_secondary;
    end else if (state_reg == ST_RUN && pending_reg != 4'h0) begin
      push = 1'b1;
      if (pending_reg[1:0] != 2'b00) begin
        push_primary   = CODE_OVERFLOW;
        push_secondary = pending_reg[0] ? 16'h0001 : 16'h0002;
      end else begin
        push_primary   = CODE_UNDERFLOW;
        push_secondary = pending_reg[2] ? 16'h0001 : 16'h0002;
      end
    end
  end

  // ===========================================================================
  // Error list and code words
  error_list u_error_list (
    .core_clk             (core_clk),
    .sys_rst              (sys_rst),
    .clear                (unit_restart),
    .push                 (push),
    .push_primary         (push_primary),
    .push_secondary       (push_secondary),
    .advance_error_list   (advance_error_list),
    .primary_error_word   (primary_error_word),
    .secondary_error_word (secondary_error_word),
    .any_error_flag       (any_error_flag),
    .entry_count          (error_count)
  );

endmodule
`default_nettype wire

// >>> bench/config_check_error_reporter_assertions.sv
// Port-level checker for the configuration checker and error reporter
`timescale 1ns/1ps
`default_nettype none
module config_check_error_reporter_assertions (
  // Clock and reset
  input wire logic                                   core_clk,
  input wire logic                                   sys_rst,
  // Unit control
  input wire logic [counter_err_pkg::UNIT_W-1:0]     unit_number,
  input wire logic                                   unit_restart,
  input wire logic                                   count_enable,
  input wire logic                                   init_busy,
  // Settings read port
  input wire logic [counter_err_pkg::ADDR_W-1:0]     settings_addr,
  input wire logic                                   settings_rd,
  // Error reporting
  input wire logic [15:0]                            primary_error_word,
  input wire logic                                   any_error_flag,
  input wire logic [counter_err_pkg::LIST_PTR_W-1:0] error_count
);
  import counter_err_pkg::*;
  int unsigned base_word;
  assign base_word = AREA_BASE_WORD + AREA_UNIT_STRIDE * unit_number;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ===========================================================================
  // Properties
  property p_reset_state;
    disable iff (1'b0)
    (sys_rst || unit_restart) |=> !count_enable && init_busy && !settings_rd
      && !any_error_flag && error_count == 5'h00 && primary_error_word == 16'h0000;
  endproperty
  property p_first_read;
    $fell(sys_rst) |-> ##[2:3] (settings_rd && settings_addr == base_word[15:0]);
  endproperty
  property p_rd_sequential;
    settings_rd && $past(settings_rd) |-> settings_addr == $past(settings_addr) + 16'h0001;
  endproperty
  property p_rd_in_area;
    settings_rd |-> init_busy && settings_addr >= base_word && settings_addr < base_word + 28;
  endproperty
  property p_no_count_busy;
    init_busy |-> !count_enable;
  endproperty
  property p_run_decision;
    $fell(init_busy) |=> count_enable == (error_count == 5'h00);
  endproperty
  property p_halt_holds;
    !init_busy && !count_enable && !unit_restart |=> !count_enable;
  endproperty
  property p_flag_holds;
    any_error_flag && !unit_restart |=> any_error_flag;
  endproperty
  property p_count_cap;
    error_count <= 5'h1e;
  endproperty
  property p_flag_tracks;
    error_count != 5'h00 |-> any_error_flag;
  endproperty
  // ===========================================================================
  // Assertions
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  a_first_read: assert property (p_first_read) else $error("first read wrong");
  a_rd_sequential: assert property (p_rd_sequential) else $error("read order wrong");
  a_rd_in_area: assert property (p_rd_in_area) else $error("read outside area");
  a_no_count_busy: assert property (p_no_count_busy) else $error("count in init");
  a_run_decision: assert property (p_run_decision) else $error("run or halt wrong");
  a_halt_holds: assert property (p_halt_holds) else $error("halt left");
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped");
  a_count_cap: assert property (p_count_cap) else $error("list too long");
  a_flag_tracks: assert property (p_flag_tracks) else $error("flag missing");
  // ===========================================================================
  // Covers
  c_run: cover property ($fell(init_busy) ##1 count_enable);
  c_halt: cover property ($fell(init_busy) ##1 !count_enable);
  c_full: cover property (error_count == 5'h1e);
endmodule
bind config_check_error_reporter config_check_error_reporter_assertions u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .unit_number(unit_number),
  .unit_restart(unit_restart), .count_enable(count_enable), .init_busy(init_busy),
  .settings_addr(settings_addr), .settings_rd(settings_rd),
  .primary_error_word(primary_error_word), .any_error_flag(any_error_flag),
  .error_count(error_count));
`default_nettype wire

// >>> bench/settings_memory_model.sv
// Host-side settings memory area with one-cycle read latency
`timescale 1ns/1ps
`default_nettype none
module settings_memory_model (
  // Clock
  input  wire logic                               core_clk,
  // Read port
  input  wire logic [counter_err_pkg::UNIT_W-1:0] unit_number,
  input  wire logic [counter_err_pkg::ADDR_W-1:0] settings_addr,
  input  wire logic                               settings_rd,
  output logic      [15:0]                        settings_data
);
  import counter_err_pkg::*;
  logic [15:0] mem [AREA_WORDS];
  logic [15:0] noise = 16'h5a5a;
  int unsigned offset;
  assign offset = settings_addr - (AREA_BASE_WORD + AREA_UNIT_STRIDE * unit_number);
  always_ff @(posedge core_clk) begin
    noise <= noise + 16'h1357;
  end
  // Outside a valid read the data line carries changing garbage
  always_ff @(posedge core_clk) begin
    if (settings_rd && offset < AREA_WORDS) begin
      settings_data <= mem[offset];
    end else begin
      settings_data <= ~noise;
    end
  end
endmodule
`default_nettype wire

// >>> bench/config_check_error_reporter_tb.sv
// Self-checking testbench for the configuration checker and error reporter
`timescale 1ns/1ps
`default_nettype none
module config_check_error_reporter_tb;
  import counter_err_pkg::*;
  logic                  core_clk           = 1'b0;
  logic                  sys_rst            = 1'b1;
  logic [UNIT_W-1:0]     unit_number        = 7'h5f;
  logic                  unit_restart       = 1'b0;
  logic [1:0]            overflow_event     = 2'b00;
  logic [1:0]            underflow_event    = 2'b00;
  logic                  advance_error_list = 1'b0;
  logic                  count_enable, init_busy, settings_rd, any_error_flag;
  logic [ADDR_W-1:0]     settings_addr;
  logic [15:0]           settings_data, primary_error_word, secondary_error_word;
  logic [LIST_PTR_W-1:0] error_count;
  int                    n_fail   = 0;
  int                    compares = 0;
  always #20 core_clk = ~core_clk;
  config_check_error_reporter dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .unit_number(unit_number),
    .unit_restart(unit_restart), .count_enable(count_enable), .init_busy(init_busy),
    .settings_addr(settings_addr), .settings_rd(settings_rd), .settings_data(settings_data),
    .overflow_event(overflow_event), .underflow_event(underflow_event),
    .advance_error_list(advance_error_list), .primary_error_word(primary_error_word),
    .secondary_error_word(secondary_error_word), .any_error_flag(any_error_flag),
    .error_count(error_count));
  settings_memory_model part (
    .core_clk(core_clk), .unit_number(unit_number), .settings_addr(settings_addr),
    .settings_rd(settings_rd), .settings_data(settings_data));
  // ===========================================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_init;
    int i;
    for (i = 0; i < 200 && init_busy !== 1'b0; i++) tick(1);
    tick(2);
  endtask
  task automatic restart;
    unit_restart = 1'b1;
    tick(1);
    unit_restart = 1'b0;
    wait_init();
  endtask
  task automatic advance;
    advance_error_list = 1'b1;
    tick(2);
    advance_error_list = 1'b0;
    tick(1);
  endtask
  task automatic check_state(input logic ce, input logic [4:0] cnt);
    check("count_enable", {15'h0000, count_enable}, {15'h0000, ce});
    check("error_count", {11'h000, error_count}, {11'h000, cnt});
    check("any_error_flag", {15'h0000, any_error_flag}, {15'h0000, cnt != 5'h00});
  endtask
  task automatic check_words(input logic [15:0] p, input logic [15:0] s);
    check("primary_error_word", primary_error_word, p);
    check("secondary_error_word", secondary_error_word, s);
  endtask
  task automatic load_good;
    logic [15:0] w [28] = '{
      16'h0001, 16'h0001, 16'h0001, 16'h0010, 16'h0100, 16'h0020, 16'h0020, 16'h0030,
      16'h0040, 16'h0050, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0001, 16'h0000, 16'h1000, 16'h0000, 16'h0010, 16'h0020, 16'h0030, 16'h0040,
      16'h0050, 16'h0060, 16'h0070, 16'h0080};
    int i;
    for (i = 0; i < 28; i++) part.mem[i] = w[i];
  endtask
  // ===========================================================================
  // Scenarios
  task automatic t_good_config;
    wait_init();
    check_state(1'b1, 5'h00);
    part.mem[2] = 16'h0002;
    tick(40);
    check_state(1'b1, 5'h00);
  endtask
  task automatic t_config_faults;
    logic [15:0] ep [7] = '{16'h0300, 16'h0331, 16'h0330, 16'h0310, 16'h0311, 16'h0320,
                            16'h0330};
    logic [15:0] es [7] = '{16'h0002, 16'h1003, 16'h1004, 16'h0016, 16'h0019, 16'h2001,
                            16'h2002};
    int i;
    unit_number = 7'h00;
    part.mem[8] = 16'h0020;
    part.mem[9] = 16'h0200;
    part.mem[16] = 16'h00a0;
    part.mem[17] = 16'h0005;
    part.mem[20] = 16'h0030;
    part.mem[22] = 16'h0001;
    restart();
    check_state(1'b0, 5'h07);
    check_words(16'h0330, 16'h2002);
    for (i = 0; i < 7; i++) begin
      advance();
      check_words(ep[i], es[i]);
    end
    advance();
    check_words(16'h0000, 16'h0000);
    advance();
    check_words(ep[0], es[0]);
    overflow_event = 2'b11;
    tick(1);
    overflow_event = 2'b00;
    tick(3);
    check_state(1'b0, 5'h07);
  endtask
  task automatic t_fix_and_reload;
    load_good();
    restart();
    check_state(1'b1, 5'h00);
    check_words(16'h0000, 16'h0000);
  endtask
  task automatic t_events;
    int i;
    overflow_event = 2'b11;
    tick(1);
    overflow_event = 2'b00;
    tick(3);
    check_state(1'b1, 5'h01);
    check_words(CODE_OVERFLOW, 16'h0001);
    underflow_event = 2'b11;
    tick(1);
    underflow_event = 2'b00;
    tick(3);
    check_state(1'b1, 5'h02);
    check_words(CODE_UNDERFLOW, 16'h0001);
    for (i = 0; i < 30; i++) begin
      overflow_event = 2'b01;
      tick(1);
      overflow_event = 2'b00;
      tick(2);
    end
    check_state(1'b1, 5'h1e);
    check_words(CODE_OVERFLOW, 16'h0001);
    advance();
    check_words(CODE_OVERFLOW, 16'h0001);
    advance();
    check_words(CODE_UNDERFLOW, 16'h0001);
  endtask
  // ===========================================================================
  // Main sequence and watchdog
  initial begin
    load_good();
    repeat (10) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    t_good_config();
    t_config_faults();
    t_fix_and_reload();
    t_events();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
